// ===== include/rms_pkg.sv
package rms_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_MISC = 8'h04;
  localparam logic [7:0] OFS_SEC = 8'h08;
  localparam logic [7:0] OFS_KEY = 8'h0c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int MISC_VISIBLE_BIT = 0;
  localparam int MISC_OSC_BIT = 1;
  localparam int MISC_MAPPED_BIT = 2;
  localparam int SEC_SECURED_BIT = 0;
  localparam int SEC_DBG_ACTIVE_BIT = 1;
  localparam int SEC_VERIFY_DONE_BIT = 2;
  localparam int SEC_VERIFY_PASS_BIT = 3;
  localparam int SEC_FLASH_EN_BIT = 4;
  localparam int SEC_EEPROM_EN_BIT = 5;
  localparam int SEC_UNSECURE_BIT = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic FLASH_VISIBLE_RESET = 1'b0;
  localparam logic SECURED_RESET = 1'b1;

  // ****************************************
  // mode patterns
  // ****************************************
  localparam logic [2:0] MODE_SPECIAL_SINGLE = 3'h0;
  localparam logic [2:0] MODE_EMUL_NARROW = 3'h1;
  localparam logic [2:0] MODE_SPECIAL_TEST = 3'h2;
  localparam logic [2:0] MODE_EMUL_WIDE = 3'h3;
  localparam logic [2:0] MODE_NORMAL_SINGLE = 3'h4;
  localparam logic [2:0] MODE_NORMAL_NARROW = 3'h5;
  localparam logic [2:0] MODE_SPECIAL_PERIPH = 3'h6;
  localparam logic [2:0] MODE_NORMAL_WIDE = 3'h7;

  // ****************************************
  // erase-verify timing
  // ****************************************
  localparam logic [7:0] VERIFY_STEPS = 8'h10;

  typedef enum logic [1:0]
  {
    VER_IDLE = 2'b00,
    VER_RUN = 2'b01,
    VER_PASS = 2'b11,
    VER_FAIL = 2'b10
  } rms_ver_state_t;

  typedef struct packed
  {
    logic [2:0] mode;
    logic flashMap;
    logic oscSel;
  } rms_strap_t;

endpackage

// ===== rtl/rms_erase_verify.sv
module rms_erase_verify (
  input wire logic clk, // system clock
  input wire logic rstN, // synchronised reset, active low
  input wire logic start, // one-cycle start pulse
  input wire logic flashErased, // flash reads fully erased
  input wire logic eepromErased, // eeprom reads fully erased
  output logic done, // walk finished, level
  output logic pass // both memories found erased
);

  rms_pkg::rms_ver_state_t stateReg;
  logic [7:0] stepReg;

  // ****************************************
  // walk over the memories
  // ****************************************
  // step counter and state, any non-erased step fails the walk
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      stateReg <= rms_pkg::VER_IDLE;
      stepReg <= 8'h00;
    end
    else
    begin
      case (stateReg)
        rms_pkg::VER_IDLE:
        begin
          if (start)
          begin
            stateReg <= rms_pkg::VER_RUN;
            stepReg <= 8'h00;
          end
        end
        rms_pkg::VER_RUN:
        begin
          if (!(flashErased && eepromErased))
            stateReg <= rms_pkg::VER_FAIL;
          else if (stepReg == rms_pkg::VERIFY_STEPS - 8'h01)
            stateReg <= rms_pkg::VER_PASS;
          else
            stepReg <= stepReg + 8'h01;
        end
        rms_pkg::VER_PASS: stateReg <= rms_pkg::VER_PASS;
        rms_pkg::VER_FAIL: stateReg <= rms_pkg::VER_FAIL;
        default: stateReg <= rms_pkg::VER_IDLE;
      endcase
    end
  end

  // status outputs
  assign done = (stateReg == rms_pkg::VER_PASS) || (stateReg == rms_pkg::VER_FAIL);
  assign pass = (stateReg == rms_pkg::VER_PASS);

endmodule

// ===== rtl/rms_config_top.sv
// Overview of operation
// - at reset release the three mode pins load the current-mode bits
// - at reset release the flash-map strap loads the flash-visible bit
// - flash appears in the memory map only while flash-visible is 1
// - mode bits are readable; only limited mode changes accepted while running
// - pattern 000: special single-chip, debug active, flash visible forced 1
// - other modes: debug allowed but idle until host sends activate command
// - pattern 001: emulation narrow, flash visible is inverse of strap
// - pattern 010: special test wide, flash visible always 0
// - pattern 011: emulation wide, strap 1 gives flash visible 0
// - pattern 100: normal single-chip, flash visible always 1
// - pattern 101: normal narrow, strap 1 gives flash visible 1
// - pattern 111: normal wide, flash visible follows the strap
// - oscillator strap high picks Colpitts, low picks Pierce or external
// - secured state comes from nonvolatile bits, kept over every reset
// - secured single-chip runs normally but refuses all debug operations
// - secured boot into expanded mode disables flash, eeprom and debug
// - special single-chip reset runs erase verify before unsecure allowed
// - reset before reprogramming the security bits leaves device secured
// - backdoor key comparison also unsecures the device
module rms_config_top (
  input wire logic core_clk, // system clock, 40 MHz
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic modeSelectC, // debug_pin strap level
  input wire logic modeSelectB, // port_e_bit6_pin strap level
  input wire logic modeSelectA, // port_e_bit5_pin strap level
  input wire logic flashMapStrap, // port_k_bit7_pin strap level
  input wire logic oscillatorSelectStrap, // port_e_bit7_pin strap level
  input wire logic securityNv, // nonvolatile security state, 1 secured
  input wire logic [31:0] backdoorKeyRef, // stored backdoor key
  input wire logic flashErased, // flash reads fully erased
  input wire logic eepromErased, // eeprom reads fully erased
  input wire logic debugActivateCmd, // serial activate command pulse
  input wire logic debugAccessReq, // host debug access attempt
  output logic debugAccessGrant, // debug access accepted
  output logic debugActive, // background debug active
  output logic flashMapped, // flash present in memory map
  output logic flashEnable, // internal flash usable
  output logic eepromEnable, // internal eeprom usable
  output logic colpittsSelect, // Colpitts oscillator chosen
  output logic pierceSelect, // Pierce or external clock chosen
  output logic [2:0] currentMode, // active operating mode
  output logic secured, // device secured
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr // APB error
);

  logic rstMeta;
  logic rstN;
  logic capturedReg;
  logic captureNow;
  rms_pkg::rms_strap_t strap;
  logic [2:0] modeReg;
  logic flashVisibleReg;
  logic oscReg;
  logic expandedBootReg;
  logic securedReg;
  logic debugActiveReg;
  logic verifyStart;
  logic verifyDone;
  logic verifyPass;
  logic setupPhase;
  logic accessWr;
  logic addrHit;
  logic modeWrite;
  logic modeWriteOk;
  logic unsecureWrite;
  logic keyMatch;
  logic strapVisible;

  // ****************************************
  // reset release
  // ****************************************
  // two-flop release of the asynchronous reset
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  // ****************************************
  // strap capture
  // ****************************************
  assign strap = '{mode: {modeSelectC, modeSelectB, modeSelectA},
                   flashMap: flashMapStrap, oscSel: oscillatorSelectStrap};
  assign captureNow = rstN && !capturedReg; // low while reset is held

  // one capture on the first edge after reset release
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      capturedReg <= 1'b0;
    else
      capturedReg <= 1'b1;
  end

  // flash-visible decode per mode pattern
  always_comb
  begin
    case (strap.mode)
      rms_pkg::MODE_SPECIAL_SINGLE: strapVisible = 1'b1;
      rms_pkg::MODE_EMUL_NARROW: strapVisible = !strap.flashMap;
      rms_pkg::MODE_SPECIAL_TEST: strapVisible = 1'b0;
      rms_pkg::MODE_EMUL_WIDE: strapVisible = !strap.flashMap;
      rms_pkg::MODE_NORMAL_SINGLE: strapVisible = 1'b1;
      rms_pkg::MODE_NORMAL_NARROW: strapVisible = strap.flashMap;
      rms_pkg::MODE_SPECIAL_PERIPH: strapVisible = 1'b1;
      rms_pkg::MODE_NORMAL_WIDE: strapVisible = strap.flashMap;
      default: strapVisible = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      modeReg <= rms_pkg::MODE_RESET;
    else if (captureNow)
      modeReg <= strap.mode;
    else if (modeWriteOk)
      modeReg <= pwdata[2:0];
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      flashVisibleReg <= rms_pkg::FLASH_VISIBLE_RESET;
    else if (captureNow)
      flashVisibleReg <= strapVisible;
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      oscReg <= 1'b0;
    else if (captureNow)
      oscReg <= strap.oscSel;
  end

  // boot mode kind, used by security gating
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      expandedBootReg <= 1'b0;
    else if (captureNow)
      expandedBootReg <= (strap.mode != rms_pkg::MODE_SPECIAL_SINGLE)
                      && (strap.mode != rms_pkg::MODE_NORMAL_SINGLE);
  end

  // ****************************************
  // security
  // ****************************************
  // secured state reloaded from nonvolatile bits
  // a reset comes out secured again only while securityNv is 1
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      securedReg <= rms_pkg::SECURED_RESET;
    else if (captureNow)
      securedReg <= securityNv;
    else if (unsecureWrite || keyMatch)
      securedReg <= 1'b0;
  end

  // active at once in special single-chip
  // other modes wait for serial command
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      debugActiveReg <= 1'b0;
    else if (captureNow)
      debugActiveReg <= (strap.mode == rms_pkg::MODE_SPECIAL_SINGLE);
    else if (debugActivateCmd)
      debugActiveReg <= 1'b1;
  end

  // erase verify after special single-chip boot
  assign verifyStart = captureNow && (strap.mode == rms_pkg::MODE_SPECIAL_SINGLE);

  rms_erase_verify u_verify (
    .clk(core_clk),
    .rstN(rstN),
    .start(verifyStart),
    .flashErased(flashErased),
    .eepromErased(eepromErased),
    .done(verifyDone),
    .pass(verifyPass)
  );

  assign flashEnable = !(securedReg && expandedBootReg);
  assign eepromEnable = !(securedReg && expandedBootReg);
  assign flashMapped = flashVisibleReg && flashEnable;
  assign debugAccessGrant = debugAccessReq && debugActiveReg && !securedReg;
  assign debugActive = debugActiveReg;
  assign colpittsSelect = oscReg;
  assign pierceSelect = !oscReg;
  assign currentMode = modeReg;
  assign secured = securedReg;

  // ****************************************
  // APB slave
  // ****************************************
  assign setupPhase = psel && !penable;
  assign accessWr = psel && penable && pwrite;
  assign addrHit = (paddr == rms_pkg::OFS_MODE) || (paddr == rms_pkg::OFS_MISC)
                || (paddr == rms_pkg::OFS_SEC) || (paddr == rms_pkg::OFS_KEY);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrHit;

  // only modes 000 to 011 may switch, never into peripheral mode
  assign modeWrite = accessWr && (paddr == rms_pkg::OFS_MODE);
  assign modeWriteOk = modeWrite && !modeReg[2]
                    && (pwdata[2:0] != rms_pkg::MODE_SPECIAL_PERIPH);
  // unsecure accepted only after a passing verify
  assign unsecureWrite = accessWr && (paddr == rms_pkg::OFS_SEC)
                      && pwdata[rms_pkg::SEC_UNSECURE_BIT] && verifyPass;
  assign keyMatch = accessWr && (paddr == rms_pkg::OFS_KEY) && (pwdata == backdoorKeyRef);

  // read data registered in the setup cycle
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      prdata <= 32'h00000000;
    else if (setupPhase && !pwrite)
    begin
      prdata <= 32'h00000000;
      case (paddr)
        rms_pkg::OFS_MODE: prdata[2:0] <= modeReg;
        rms_pkg::OFS_MISC:
        begin
          prdata[rms_pkg::MISC_VISIBLE_BIT] <= flashVisibleReg;
          prdata[rms_pkg::MISC_OSC_BIT] <= oscReg;
          prdata[rms_pkg::MISC_MAPPED_BIT] <= flashMapped;
        end
        rms_pkg::OFS_SEC:
        begin
          prdata[rms_pkg::SEC_SECURED_BIT] <= securedReg;
          prdata[rms_pkg::SEC_DBG_ACTIVE_BIT] <= debugActiveReg;
          prdata[rms_pkg::SEC_VERIFY_DONE_BIT] <= verifyDone;
          prdata[rms_pkg::SEC_VERIFY_PASS_BIT] <= verifyPass;
          prdata[rms_pkg::SEC_FLASH_EN_BIT] <= flashEnable;
          prdata[rms_pkg::SEC_EEPROM_EN_BIT] <= eepromEnable;
        end
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstN);

  chk_mode_capture: assert property (captureNow |=> modeReg == $past(strap.mode))
    else $error("mode bits not loaded from pins");

  chk_visible_capture: assert property (captureNow |=> flashVisibleReg == $past(strapVisible))
    else $error("flash visible not loaded at release");

  chk_map_gate: assert property (flashMapped |-> flashVisibleReg && flashEnable)
    else $error("flash mapped while not visible");

  chk_special_boot: assert property (captureNow && strap.mode == rms_pkg::MODE_SPECIAL_SINGLE
    |=> flashVisibleReg && debugActive && !verifyDone)
    else $error("special single chip boot wrong");

  chk_test_hidden: assert property (captureNow && strap.mode == rms_pkg::MODE_SPECIAL_TEST
    |=> !flashVisibleReg [*3])
    else $error("flash visible in special test mode");

  chk_debug_block: assert property (secured |-> !debugAccessGrant)
    else $error("debug granted while secured");

  chk_expanded_lock: assert property (capturedReg && secured && expandedBootReg
    |-> !flashEnable && !eepromEnable && !flashMapped)
    else $error("memories enabled in secured expanded boot");

  chk_verify_gate: assert property (capturedReg && secured && !verifyPass && !keyMatch
    |=> secured)
    else $error("unsecured without passing verify");

  chk_strap_hold: assert property (capturedReg |=> $stable(flashVisibleReg) && $stable(oscReg))
    else $error("strap values changed after release");

  chk_osc_select: assert property (captureNow |=> colpittsSelect == $past(strap.oscSel)
    && pierceSelect != colpittsSelect)
    else $error("oscillator select wrong");

  chk_debug_activate: assert property (capturedReg && debugActivateCmd |=> debugActive)
    else $error("debug not activated by host command");

  // mode bits locked in normal modes
  chk_mode_lock: assert property (capturedReg && modeReg[2] |=> $stable(modeReg))
    else $error("mode bits changed in a normal mode");

  chk_mode_no_periph: assert property (capturedReg && modeWrite
    && pwdata[2:0] == rms_pkg::MODE_SPECIAL_PERIPH |=> $stable(modeReg))
    else $error("mode bits switched to peripheral pattern");

  chk_key_unsecure: assert property (keyMatch |=> !secured)
    else $error("backdoor key match left device secured");

endmodule

// ===== dv/rms_board_model.sv
// *****
// board straps and debug host
// *****
module rms_board_model (
  input wire logic clk, // system clock
  input wire rms_pkg::rms_strap_t strapReq, // levels to strap
  input wire logic strapHold, // hold straps steady
  input wire logic activateReq, // host wants debug active
  input wire logic accessReq, // host access attempt
  input wire logic eraseReq, // host erased both memories
  output logic modeSelectC, // mode pin c
  output logic modeSelectB, // mode pin b
  output logic modeSelectA, // mode pin a
  output logic flashMapStrap, // flash-map pin
  output logic oscillatorSelectStrap, // oscillator pin
  output logic flashErased, // flash erased level
  output logic eepromErased, // eeprom erased level
  output logic debugActivateCmd, // activate pulse
  output logic debugAccessReq // access level
);
  timeunit 1ns;
  timeprecision 1ps;
  rms_pkg::rms_strap_t pinReg;
  logic actReg;

  // straps held, then pins reused and moving every cycle
  always_ff @(posedge clk)
  begin
    if (strapHold)
    begin
      pinReg <= strapReq;
      if (strapReq.mode == rms_pkg::MODE_SPECIAL_PERIPH)
        pinReg.mode <= rms_pkg::MODE_NORMAL_SINGLE;
    end
    else
      pinReg <= ~pinReg;
    actReg <= activateReq;
  end

  // pin levels
  assign modeSelectC = pinReg.mode[2];
  assign modeSelectB = pinReg.mode[1];
  assign modeSelectA = pinReg.mode[0];
  assign flashMapStrap = pinReg.flashMap;
  assign oscillatorSelectStrap = pinReg.oscSel;
  // serial activate command as one-cycle pulse
  assign debugActivateCmd = activateReq & ~actReg;
  assign debugAccessReq = accessReq;
  assign flashErased = eraseReq;
  assign eepromErased = eraseReq;
endmodule

// ===== dv/reset_mode_strap_and_security_bench.sv
module reset_mode_strap_and_security_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, arst_n, securityNv, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, backdoorKeyRef, prdata;
  rms_pkg::rms_strap_t strapReq;
  logic strapHold, activateReq, accessReq, eraseReq;
  logic modeSelectC, modeSelectB, modeSelectA, flashMapStrap, oscillatorSelectStrap;
  logic flashErased, eepromErased, debugActivateCmd, debugAccessReq;
  logic debugAccessGrant, debugActive, flashMapped, flashEnable, eepromEnable;
  logic colpittsSelect, pierceSelect, secured, pready, pslverr;
  logic [2:0] currentMode;
  logic [32:0] expQ[$];
  int nFail;
  int nTests;
  logic osc, nv, vis, en;

  // *****
  // design and far side
  // *****
  rms_config_top u_dut (.core_clk(core_clk), .arst_n(arst_n), .modeSelectC(modeSelectC),
    .modeSelectB(modeSelectB), .modeSelectA(modeSelectA), .flashMapStrap(flashMapStrap),
    .oscillatorSelectStrap(oscillatorSelectStrap), .securityNv(securityNv),
    .backdoorKeyRef(backdoorKeyRef), .flashErased(flashErased), .eepromErased(eepromErased),
    .debugActivateCmd(debugActivateCmd), .debugAccessReq(debugAccessReq),
    .debugAccessGrant(debugAccessGrant), .debugActive(debugActive), .flashMapped(flashMapped),
    .flashEnable(flashEnable), .eepromEnable(eepromEnable), .colpittsSelect(colpittsSelect),
    .pierceSelect(pierceSelect), .currentMode(currentMode), .secured(secured), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  rms_board_model u_board (.clk(core_clk), .strapReq(strapReq), .strapHold(strapHold),
    .activateReq(activateReq), .accessReq(accessReq), .eraseReq(eraseReq),
    .modeSelectC(modeSelectC), .modeSelectB(modeSelectB), .modeSelectA(modeSelectA),
    .flashMapStrap(flashMapStrap), .oscillatorSelectStrap(oscillatorSelectStrap),
    .flashErased(flashErased), .eepromErased(eepromErased),
    .debugActivateCmd(debugActivateCmd), .debugAccessReq(debugAccessReq));

  // 25 ns clock
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // *****
  // tasks
  // *****
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      nFail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic endOfTest;
    $display("compares %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one apb transfer, held until pready seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      nFail++;
      endOfTest();
    end
  endtask

  // read with expected word and error noted
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
    expQ.push_back({err, d});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // reset with straps held over release
  task automatic boot(input logic [2:0] m, input logic fm, input logic o, input logic s, input int hold);
    @(posedge core_clk);
    arst_n <= 1'b0;
    strapReq <= '{mode: m, flashMap: fm, oscSel: o};
    strapHold <= 1'b1;
    securityNv <= s;
    activateReq <= 1'b0;
    accessReq <= 1'b0;
    repeat (hold) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    strapHold <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // activate debug from host and attempt access in the same cycle
  task automatic debugTry(input logic grant);
    @(posedge core_clk);
    activateReq <= 1'b1;
    accessReq <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check(debugActive, 1'b1);
    check(debugAccessGrant, grant);
  endtask

  // *****
  // read result watcher
  // *****
  always @(posedge core_clk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
    begin
      if (expQ.size() == 0)
        check(33'h1_ffff_ffff, 33'h0);
      else
        check({pslverr, prdata}, expQ.pop_front());
    end
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk);
    nFail++;
    $display("BAD %0t run did not finish", $time);
    endOfTest();
  end

  // *****
  // main sequence
  // *****
  initial
  begin
    void'($urandom(66));
    {arst_n, securityNv, psel, penable, pwrite, activateReq, accessReq, eraseReq} = '0;
    strapHold = 1'b1;
    strapReq = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    backdoorKeyRef = $urandom();
    boot(3'h4, 1'b0, 1'b0, 1'b0, 20);
    // every strap pattern except 110 with both flash-map levels
    for (int m = 0; m < 8; m++)
      for (int s = 0; s < 2; s++)
        if (m != 6)
        begin
          osc = $urandom();
          nv = $urandom();
          vis = (m == 0 || m == 4) ? 1'b1 : (m == 1 || m == 3) ? !s[0] : (m == 2) ? 1'b0 : s[0];
          en = !(nv && m != 0 && m != 4);
          boot(m[2:0], s[0], osc, nv, 2);
          check(currentMode, m[2:0]);
          check(debugActive, m == 0);
          check(flashEnable, en);
          check(eepromEnable, en);
          check(flashMapped, vis & en);
          check(colpittsSelect, osc);
          check(pierceSelect, !osc);
          check(secured, nv);
          rd(rms_pkg::OFS_MISC, {29'h0, vis & en, osc, vis}, 1'b0);
          rd(rms_pkg::OFS_MODE, {29'h0, m[2:0]}, 1'b0);
          debugTry(!nv);
        end
    // mode writes from special mode, then locked in normal mode
    boot(3'h0, 1'b0, 1'b0, 1'b0, 2);
    apb(1'b1, rms_pkg::OFS_MODE, 32'h0000_0006);
    rd(rms_pkg::OFS_MODE, 32'h0000_0000, 1'b0);
    apb(1'b1, rms_pkg::OFS_MODE, 32'h0000_0005);
    rd(rms_pkg::OFS_MODE, 32'h0000_0005, 1'b0);
    apb(1'b1, rms_pkg::OFS_MODE, 32'h0000_0001);
    rd(rms_pkg::OFS_MODE, 32'h0000_0005, 1'b0);
    rd(8'h10, 32'h0000_0000, 1'b1);
    // erased memories, verify passes, unsecure accepted
    eraseReq <= 1'b1;
    boot(3'h0, 1'b0, 1'b0, 1'b1, 2);
    repeat (20) @(posedge core_clk);
    rd(rms_pkg::OFS_SEC, 32'h0000_003f, 1'b0);
    apb(1'b1, rms_pkg::OFS_SEC, 32'h0000_0001);
    @(negedge core_clk);
    check(secured, 1'b0);
    rd(rms_pkg::OFS_SEC, 32'h0000_003e, 1'b0);
    boot(3'h0, 1'b0, 1'b0, 1'b1, 2);
    check(secured, 1'b1);
    // memory not erased, verify fails, unsecure refused
    eraseReq <= 1'b0;
    boot(3'h0, 1'b0, 1'b0, 1'b1, 2);
    repeat (20) @(posedge core_clk);
    rd(rms_pkg::OFS_SEC, 32'h0000_0037, 1'b0);
    apb(1'b1, rms_pkg::OFS_SEC, 32'h0000_0001);
    @(negedge core_clk);
    check(secured, 1'b1);
    // backdoor key in normal single-chip
    boot(3'h4, 1'b1, 1'b1, 1'b1, 2);
    apb(1'b1, rms_pkg::OFS_SEC, 32'h0000_0001);
    apb(1'b1, rms_pkg::OFS_KEY, ~backdoorKeyRef);
    @(negedge core_clk);
    check(secured, 1'b1);
    apb(1'b1, rms_pkg::OFS_KEY, backdoorKeyRef);
    @(negedge core_clk);
    check(secured, 1'b0);
    debugTry(1'b1);
    repeat (4) @(posedge core_clk);
    check(expQ.size(), 33'h0);
    endOfTest();
  end
endmodule
